/* pkg/ecc_report_pkg.sv */
// Package with constants and types for the ECC error reporting block.
package ecc_report_pkg;
   localparam int EVENT_W = 30;
   localparam int BIT_IN_HANDLER = 0;
   localparam int BIT_RF_CORR = 1;
   localparam int BIT_RF_UNCORR = 2;
   localparam int BIT_IC_TAG = 3;
   localparam int BIT_IC_DATA = 4;
   localparam int BIT_XL_HW_CORR = 19;
   localparam int BIT_XL_HW_UNCORR = 20;
   localparam int BIT_XL_SW = 21;
   localparam logic [29:0] EVENT_RESET = 30'h0;
   localparam logic [31:0] APB_RDATA_RESET = 32'h0;
   localparam logic [11:0] ADDR_CONFIG = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_MASK = 12'h008;
   localparam logic [11:0] ADDR_XLATE = 12'h00c;
   localparam int CFG_CHECK_EN = 0;
   localparam int CFG_EXC_EN = 1;
   localparam int CFG_HANDLER = 2;
   localparam logic [2:0] CONFIG_RESET = 3'h0;
   localparam logic [29:0] STATUS_RESET = 30'h0;
   localparam logic [29:0] MASK_RESET = 30'h0;

   // Syndrome classification reported by each RAM check.
   typedef enum logic [1:0]
   {
      ERR_NONE = 2'b00,
      ERR_SINGLE = 2'b01,
      ERR_DOUBLE = 2'b10,
      ERR_TRIPLE = 2'b11
   } err_class_t;

   typedef struct packed
   {
      logic valid;
      err_class_t cls;
   } check_result_t;

   typedef struct packed
   {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;
endpackage : ecc_report_pkg

/* logic/core_ecc_error_reporting.sv */
// ECC error classification, recovery requests and event bus for the core RAMs.
`timescale 1ns/1ns
// Notes on behaviour
// - Check instruction cache, register file, translation buffer.
// - Cache errors invalidate line and refetch.
// - Register file single errors corrected silently.
// - Register file double errors raise exception.
// - Translation hardware single errors corrected silently.
// - Translation hardware double errors raise exception.
// - Software translation reads set flag, no exception.
// - Errors published on streaming event bus.
// - Event bits set even with checks disabled.
// - Bit 0 marks exception inside handler.
// - Bits 1, 2 mark register file errors.
// - Bits 3, 4 mark cache tag, data errors.
// - Bits 19-21 mark translation buffer errors.
module core_ecc_error_reporting #(
   parameter bit HAS_ICACHE = 1'b1,
   parameter bit HAS_XLATE = 1'b1
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB register port.
   input wire ecc_report_pkg::apb_req_t apb_req,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Check results from the protected RAMs.
   input wire ecc_report_pkg::check_result_t ic_tag_check,
   input wire ecc_report_pkg::check_result_t ic_data_check,
   input wire ecc_report_pkg::check_result_t rf_check,
   input wire ecc_report_pkg::check_result_t xl_hw_check,
   input wire ecc_report_pkg::check_result_t xl_sw_check,
   // Recovery actions toward the core.
   output logic icache_invalidate,
   output logic icache_refetch,
   output logic rf_correct,
   output logic xl_hw_correct,
   output logic ecc_exception,
   // Streaming event bus.
   output logic [29:0] event_data,
   output logic event_valid,
   // Interrupt.
   output logic irq
);
   import ecc_report_pkg::*;

   logic [2:0] config_reg;
   logic [29:0] status;
   logic [29:0] mask;
   logic xlate_sw_error_bit;
   logic [29:0] next_events;
   logic check_enable_bit;
   logic check_exception_enable_bit;
   logic handler_mode_bit;
   logic ic_err;
   logic ic_tag_err;
   logic ic_data_err;
   logic rf_single;
   logic rf_double;
   logic xl_single;
   logic xl_double;
   logic xl_sw_err;
   logic exc_cause;
   logic wr_access;
   logic rd_access;
   logic addr_ok;
   logic setup_access;
   logic setup_read;

   assign check_enable_bit = config_reg[CFG_CHECK_EN];
   assign check_exception_enable_bit = config_reg[CFG_EXC_EN];
   assign handler_mode_bit = config_reg[CFG_HANDLER];

   // Classification of each RAM's check result.
   syndrome_sort #(
      .PRESENT(HAS_ICACHE)
   ) u_ic_tag (
      .result(ic_tag_check),
      .any_err(ic_tag_err),
      .single_err(),
      .double_err()
   );

   syndrome_sort #(
      .PRESENT(HAS_ICACHE)
   ) u_ic_data (
      .result(ic_data_check),
      .any_err(ic_data_err),
      .single_err(),
      .double_err()
   );

   syndrome_sort #(
      .PRESENT(1'b1)
   ) u_rf (
      .result(rf_check),
      .any_err(),
      .single_err(rf_single),
      .double_err(rf_double)
   );

   syndrome_sort #(
      .PRESENT(HAS_XLATE)
   ) u_xl_hw (
      .result(xl_hw_check),
      .any_err(),
      .single_err(xl_single),
      .double_err(xl_double)
   );

   syndrome_sort #(
      .PRESENT(HAS_XLATE)
   ) u_xl_sw (
      .result(xl_sw_check),
      .any_err(xl_sw_err),
      .single_err(),
      .double_err()
   );

   assign ic_err = ic_tag_err || ic_data_err;
   assign exc_cause = rf_double || xl_double;

   // Event vector, independent of the enable bits.
   always_comb
   begin
      next_events = EVENT_RESET;
      next_events[BIT_IN_HANDLER] = exc_cause && handler_mode_bit;
      next_events[BIT_RF_CORR] = rf_single;
      next_events[BIT_RF_UNCORR] = rf_double;
      next_events[BIT_IC_TAG] = ic_tag_err;
      next_events[BIT_IC_DATA] = ic_data_err;
      next_events[BIT_XL_HW_CORR] = xl_single;
      next_events[BIT_XL_HW_UNCORR] = xl_double;
      next_events[BIT_XL_SW] = xl_sw_err;
   end

   // Event bus registers, one-cycle pulses.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         event_data <= EVENT_RESET;
      else
         event_data <= next_events;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         event_valid <= 1'b0;
      else
         event_valid <= |next_events;
   end

   // Recovery actions, gated by the configuration enables.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         icache_invalidate <= 1'b0;
      else
         icache_invalidate <= check_enable_bit && ic_err;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         icache_refetch <= 1'b0;
      else
         icache_refetch <= check_enable_bit && ic_err;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rf_correct <= 1'b0;
      else
         rf_correct <= check_enable_bit && rf_single;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         xl_hw_correct <= 1'b0;
      else
         xl_hw_correct <= check_enable_bit && xl_single;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ecc_exception <= 1'b0;
      else
         ecc_exception <= check_enable_bit && check_exception_enable_bit && exc_cause;
   end

   // APB decode; single-cycle access.
   assign setup_access = apb_req.psel && !apb_req.penable;
   assign setup_read = setup_access && !apb_req.pwrite;
   assign wr_access = apb_req.psel && apb_req.penable && apb_req.pwrite;
   assign rd_access = apb_req.psel && apb_req.penable && !apb_req.pwrite;
   assign addr_ok = apb_req.paddr == ADDR_CONFIG || apb_req.paddr == ADDR_STATUS ||
      apb_req.paddr == ADDR_MASK || apb_req.paddr == ADDR_XLATE;

   // Configuration and mask registers.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         config_reg <= CONFIG_RESET;
      else if (wr_access && apb_req.paddr == ADDR_CONFIG)
         config_reg <= apb_req.pwdata[2:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mask <= MASK_RESET;
      else if (wr_access && apb_req.paddr == ADDR_MASK)
         mask <= apb_req.pwdata[29:0];
   end

   // Sticky status, write one to clear; a new event wins over the clear.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         status <= STATUS_RESET;
      else if (wr_access && apb_req.paddr == ADDR_STATUS)
         status <= (status & ~apb_req.pwdata[29:0]) | next_events;
      else
         status <= status | next_events;
   end

   // Software read error bit, set by hardware, cleared by writing a one.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         xlate_sw_error_bit <= 1'b0;
      else if (xl_sw_err)
         xlate_sw_error_bit <= 1'b1;
      else if (wr_access && apb_req.paddr == ADDR_XLATE && apb_req.pwdata[0])
         xlate_sw_error_bit <= 1'b0;
   end

   // Ready and error response, one cycle after setup.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pready <= 1'b0;
      else
         pready <= setup_access;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pslverr <= 1'b0;
      else
         pslverr <= setup_access && !addr_ok;
   end

   // Read data, valid in the access cycle of a read.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= APB_RDATA_RESET;
      else if (setup_read)
      begin
         case (apb_req.paddr)
            ADDR_CONFIG: prdata <= {29'h0, config_reg};
            ADDR_STATUS: prdata <= {2'h0, status};
            ADDR_MASK: prdata <= {2'h0, mask};
            ADDR_XLATE: prdata <= {31'h0, xlate_sw_error_bit};
            default: prdata <= APB_RDATA_RESET;
         endcase
      end
      else if (!rd_access)
         prdata <= APB_RDATA_RESET;
   end

   // Interrupt level from unmasked sticky status.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq <= 1'b0;
      else
         irq <= |(status & mask);
   end
endmodule : core_ecc_error_reporting

// Sorts one RAM's check result into its error classes.
module syndrome_sort #(
   parameter bit PRESENT = 1'b1
) (
   // Check result from one RAM.
   input wire ecc_report_pkg::check_result_t result,
   // Error classes found.
   output logic any_err,
   output logic single_err,
   output logic double_err
);
   import ecc_report_pkg::*;

   assign any_err = PRESENT && result.valid && result.cls != ERR_NONE;
   assign single_err = PRESENT && result.valid && result.cls == ERR_SINGLE;
   assign double_err = PRESENT && result.valid && result.cls == ERR_DOUBLE;
endmodule : syndrome_sort

/* tb/ecc_event_monitor.sv */
// Monitor model of the logic that watches the ECC event bus.
`timescale 1ns/1ns
module ecc_event_monitor (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Event stream.
   input wire logic [29:0] event_data,
   input wire logic event_valid,
   // Last word taken.
   output logic [29:0] seen
);
   // Takes a word only while the source marks it valid.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         seen <= '0;
      else if (event_valid)
         seen <= event_data;
   end
endmodule : ecc_event_monitor

/* tb/core_ecc_error_reporting_asserts.sv */
// Checker for the event bus of the ECC error reporting block.
`timescale 1ns/1ns
module core_ecc_error_reporting_asserts (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Observed ports.
   input wire ecc_report_pkg::check_result_t rf_check,
   input wire ecc_report_pkg::check_result_t xl_hw_check,
   input wire ecc_report_pkg::check_result_t ic_tag_check,
   input wire ecc_report_pkg::check_result_t xl_sw_check,
   input wire logic [29:0] event_data,
   input wire logic event_valid,
   input wire logic rf_correct,
   input wire logic ecc_exception
);
   import ecc_report_pkg::*;
   wire rf_single = rf_check.valid && rf_check.cls == ERR_SINGLE;
   wire rf_double = rf_check.valid && rf_check.cls == ERR_DOUBLE;
   wire any_double = rf_double || (xl_hw_check.valid && xl_hw_check.cls == ERR_DOUBLE);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   rf_corr_flag_a: assert property (rf_single |=> event_data[BIT_RF_CORR])
      else $error("register file single flag missing");
   rf_uncorr_flag_a: assert property (rf_double |=> event_data[BIT_RF_UNCORR])
      else $error("register file double flag missing");
   icache_tag_flag_a: assert property (ic_tag_check.valid && ic_tag_check.cls != ERR_NONE
      |=> event_data[BIT_IC_TAG]) else $error("cache tag flag missing");
   xlate_hw_flag_a: assert property (xl_hw_check.valid && xl_hw_check.cls == ERR_SINGLE
      |=> event_data[BIT_XL_HW_CORR]) else $error("translation single flag missing");
   xlate_sw_flag_a: assert property (xl_sw_check.valid && xl_sw_check.cls != ERR_NONE
      && !any_double |=> event_data[BIT_XL_SW] && !ecc_exception) else $error("sw read fault");
   reserved_zero_a: assert property (event_data[18:5] == 14'h0 && event_data[29:22] == 8'h0)
      else $error("reserved event bit set");
   valid_match_a: assert property (event_valid == (|event_data))
      else $error("event valid disagrees with data");
   no_silent_exc_a: assert property (!any_double |=> !ecc_exception)
      else $error("exception without double error");
   single_pulse_a: assert property (!rf_single |=> !event_data[BIT_RF_CORR])
      else $error("single flag held too long");
   cover property (ecc_exception);
   cover property (event_data[BIT_IN_HANDLER]);
   cover property (rf_correct);
   cover property (event_data[BIT_XL_SW]);
endmodule : core_ecc_error_reporting_asserts
bind core_ecc_error_reporting core_ecc_error_reporting_asserts u_chk (.pclk, .presetn,
   .rf_check, .xl_hw_check, .ic_tag_check, .xl_sw_check, .event_data, .event_valid,
   .rf_correct, .ecc_exception);

/* tb/core_ecc_error_reporting_tb.sv */
// Testbench for the ECC error reporting block.
`timescale 1ns/1ns
module core_ecc_error_reporting_tb;
   import ecc_report_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   apb_req_t apb_req = '0;
   check_result_t chk [5] = '{default: '0};
   logic [31:0] prdata;
   logic pready, pslverr, irq, event_valid, inv, ref_f, rfc, xlc, exc;
   logic [29:0] event_data, seen;
   int err_count = 0;
   int compares = 0;
   always #5 pclk = ~pclk;
   core_ecc_error_reporting u_dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ic_tag_check(chk[0]),
      .ic_data_check(chk[1]), .rf_check(chk[2]), .xl_hw_check(chk[3]), .xl_sw_check(chk[4]),
      .icache_invalidate(inv), .icache_refetch(ref_f), .rf_correct(rfc), .xl_hw_correct(xlc),
      .ecc_exception(exc), .event_data(event_data), .event_valid(event_valid), .irq(irq));
   ecc_event_monitor u_mon (.pclk(pclk), .presetn(presetn), .event_data(event_data),
      .event_valid(event_valid), .seen(seen));
   task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
      compares++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [32:0] exp);
      @(posedge pclk);
      apb_req <= '{1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      cmp({pslverr, prdata}, exp);
      apb_req <= '0;
   endtask : acc
   task automatic hit(input int k, input err_class_t c, input logic [29:0] ev,
      input logic [4:0] ac);
      @(posedge pclk);
      chk[k] <= '{1'b1, c};
      @(posedge pclk);
      chk[k] <= '0;
      #1;
      cmp(33'(event_data), 33'(ev));
      cmp(33'({inv, ref_f, rfc, xlc, exc}), 33'(ac));
      @(posedge pclk);
      #1;
      cmp(33'(event_data), 33'h0);
      if (|ev)
         cmp(33'(seen), 33'(ev));
   endtask : hit
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : complete_run
   initial
   begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 4; i++)
         acc(1'b0, 12'(4 * i), '0, '0);
      acc(1'b0, 12'h010, '0, {1'b1, 32'h0});
      $display("register test done");
      hit(2, ERR_SINGLE, 30'h2, 5'b00000);
      hit(2, ERR_DOUBLE, 30'h4, 5'b00000);
      acc(1'b1, ADDR_CONFIG, 32'h1, '0);
      hit(2, ERR_DOUBLE, 30'h4, 5'b00000);
      hit(2, ERR_TRIPLE, 30'h0, 5'b00000);
      acc(1'b1, ADDR_CONFIG, 32'h3, '0);
      hit(2, ERR_SINGLE, 30'h2, 5'b00100);
      hit(2, ERR_DOUBLE, 30'h4, 5'b00001);
      hit(2, ERR_NONE, 30'h0, 5'b00000);
      hit(3, ERR_SINGLE, 30'h80000, 5'b00010);
      hit(3, ERR_DOUBLE, 30'h100000, 5'b00001);
      for (int c = 1; c < 4; c++)
      begin
         hit(0, err_class_t'(c), 30'h8, 5'b11000);
         hit(1, err_class_t'(c), 30'h10, 5'b11000);
         hit(4, err_class_t'(c), 30'h200000, 5'b00000);
      end
      acc(1'b0, ADDR_XLATE, '0, 33'h1);
      acc(1'b1, ADDR_XLATE, 32'h1, '0);
      acc(1'b0, ADDR_XLATE, '0, '0);
      acc(1'b1, ADDR_CONFIG, 32'h7, '0);
      hit(2, ERR_DOUBLE, 30'h5, 5'b00001);
      hit(3, ERR_DOUBLE, 30'h100001, 5'b00001);
      $display("event test done");
      acc(1'b0, ADDR_STATUS, '0, 33'h38001f);
      cmp(33'(irq), 33'h0);
      acc(1'b1, ADDR_MASK, 32'h2, '0);
      @(posedge pclk);
      #1;
      cmp(33'(irq), 33'h1);
      acc(1'b1, ADDR_STATUS, 32'h2, '0);
      @(posedge pclk);
      #1;
      cmp(33'(irq), 33'h0);
      acc(1'b0, ADDR_STATUS, '0, 33'h38001d);
      $display("interrupt test done");
      presetn <= 1'b0;
      @(posedge pclk);
      #1;
      cmp(33'({pready, pslverr, irq, event_valid, inv, ref_f, rfc, xlc, exc}), 33'h0);
      cmp(33'(event_data), 33'h0);
      @(posedge pclk);
      presetn <= 1'b1;
      acc(1'b0, ADDR_STATUS, '0, '0);
      acc(1'b0, ADDR_CONFIG, '0, '0);
      $display("reset test done");
      complete_run();
   end
   initial
   begin
      #20000;
      err_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      complete_run();
   end
endmodule : core_ecc_error_reporting_tb
